// ===== hdl/ldo_regs.sv
// option registers of the floppy, parallel and serial/infrared devices
// assumes a plain config port with a 16-bit address {device, index}
`timescale 1ns/1ps
`include "ldo_defs.svh"
`default_nettype none
// Contract
// - drive option reg holds type bits 1:0, rate table 4:3; bits 2,5,7 read 0.
// - bit 6 set disables write precompensation for that drive.
// - second drive register mirrors first drive layout and default.
// - parallel mode field bits 2:0 selects printer, SPP, EPP, ECP combinations.
// - bits 6:3 hold ECP FIFO threshold, default 0111.
// - interrupt type one gives low pulse, then released to high impedance.
// - interrupt type zero makes interrupt follow nACK in EPP-like modes.
// - type ignored in printer/SPP; level interrupt in ECP, TEST, FIFO.
// - timeout flag clears on write one; with ppx bit 4 set, on read trailing edge instead.
// - bit 0 of serial mode enables MIDI, default off.
// - bit 1 of serial mode enables high speed, default off.
// - bit 7 of first serial mode makes UARTs share one interrupt.
// - with sharing on, either UART interrupt asserts both lines.
// - second UART transmit idles low at zero, high impedance at one.
// - infrared bits invert receive and transmit polarity; reset 0x02.
// - infrared bit 2 selects half duplex, default full duplex.
// - infrared mode 000 serial, 001 IrDA, 010 amplitude keyed; rest reserved.
// - infrared bit 6 routes signals to alternate infrared pins.
// - half duplex blanks receiver during transmit plus count times 100 us, count capped at 100.
// - registers take defaults on power-on, standby power-on and hard reset.
// - transmit idle bit resets only on standby power-on reset.
// - soft reset leaves these registers unchanged.
module ldo_regs #(
	parameter int TICK_CYCLES = `LDO_TICK_US * `LDO_CLK_MHZ
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              STBY_POR,
	input  wire logic [15:0]       ADDR,
	input  wire logic [7:0]        WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic [7:0]             RDATA,
	output ldo_pkg::ldo_drive_t    DRIVE0_OPTIONS,
	output ldo_pkg::ldo_drive_t    DRIVE1_OPTIONS,
	output logic [2:0]             PP_MODE,
	output logic [3:0]             PP_FIFO_THR,
	input  wire logic [2:0]        PP_ECR_MODE,
	input  wire logic              PP_NACK,
	input  wire logic              PP_LVL_IRQ,
	output logic                   PP_IRQ_O,
	output logic                   PP_IRQ_OE,
	input  wire logic              EPP_TMO_SET,
	input  wire logic              EPP_STAT_WR,
	input  wire logic              EPP_STAT_WD,
	input  wire logic              EPP_STAT_RD,
	output logic                   EPP_TIMEOUT_FLAG,
	output logic                   U1_MIDI,
	output logic                   U1_HS,
	output logic                   U2_MIDI,
	output logic                   U2_HS,
	input  wire logic              U1_IRQ_IN,
	input  wire logic              U2_IRQ_IN,
	output logic                   U1_IRQ,
	output logic                   U2_IRQ,
	output logic [2:0]             IR_MODE,
	input  wire logic              U2_TXD,
	input  wire logic              U2_TX_ACTIVE,
	output logic                   U2_RXD,
	output logic                   SECOND_SERIAL_TX_O,
	output logic                   SECOND_SERIAL_TX_OE,
	input  wire logic              SECOND_SERIAL_RX,
	input  wire logic              ALT_INFRARED_RX,
	output logic                   ALT_INFRARED_TX
);
	import ldo_pkg::*;

	// ==========================================
	// state
	localparam ldo_st_t ST_RST = '{
		drv0:   `LDO_RST_DRV,
		drv1:   `LDO_RST_DRV,
		ppm:    `LDO_RST_PPM,
		ppx:    `LDO_RST_PPX,
		sp1:    `LDO_RST_SER,
		sp2:    `LDO_RST_SER,
		iro:    `LDO_RST_IRO,
		irb:    `LDO_RST_IRB,
		rxd:    1'b1,
		default: '0
	};
	localparam logic [7:0] BMAX = 8'(`LDO_BLANK_MAX);
	localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

	ldo_st_t    s_q;
	ldo_st_t    s_d;
	logic       idle_q;
	logic       quiet_q;
	logic [7:0] rv;
	logic       h_drv0;
	logic       h_drv1;
	logic       h_ppm;
	logic       h_ppx;
	logic       h_sp1;
	logic       h_sp2;
	logic       h_iro;
	logic       h_irb;
	logic       ecp;
	logic       lvl_cfg;
	logic       plain_cfg;
	logic       pulse_cfg;
	logic       ir_on;
	logic       half;
	logic       blank;
	logic       tick;
	logic       tmo_clr;
	logic       any_irq;
	logic       ir_tx;

	// ==========================================
	// address decode
	assign h_drv0 = ADDR == {`LDO_LD_FDC, `LDO_IX_DRV0};
	assign h_drv1 = ADDR == {`LDO_LD_FDC, `LDO_IX_DRV1};
	assign h_ppm  = ADDR == {`LDO_LD_PP, `LDO_IX_PPM};
	assign h_ppx  = ADDR == {`LDO_LD_PP, `LDO_IX_PPX};
	assign h_sp1  = ADDR == {`LDO_LD_SP1, `LDO_IX_SER};
	assign h_sp2  = ADDR == {`LDO_LD_SP2, `LDO_IX_SER};
	assign h_iro  = ADDR == {`LDO_LD_SP2, `LDO_IX_IRO};
	assign h_irb  = ADDR == {`LDO_LD_SP2, `LDO_IX_IRB};

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		// read mux; unmapped addresses return zero
		rv = 8'h00;
		if (h_drv0) begin
			rv = s_q.drv0;
		end
		if (h_drv1) begin
			rv = s_q.drv1;
		end
		if (h_ppm) begin
			rv = s_q.ppm;
		end
		if (h_ppx) begin
			rv = s_q.ppx;
		end
		if (h_sp1) begin
			rv = s_q.sp1;
		end
		if (h_sp2) begin
			rv = s_q.sp2;
			rv[`LDO_B_TXIDLE] = idle_q;
		end
		if (h_iro) begin
			rv = s_q.iro;
		end
		if (h_irb) begin
			rv = s_q.irb;
		end
		s_d.rdata = RD ? rv : 8'h00;

		// writes keep only defined bits
		if (WR) begin
			if (h_drv0) begin
				s_d.drv0 = WDATA & `LDO_MSK_DRV;
			end
			if (h_drv1) begin
				s_d.drv1 = WDATA & `LDO_MSK_DRV;
			end
			if (h_ppm) begin
				s_d.ppm = WDATA;
			end
			if (h_ppx) begin
				s_d.ppx = WDATA & `LDO_MSK_PPX;
			end
			if (h_sp1) begin
				s_d.sp1 = WDATA & `LDO_MSK_SP1;
			end
			if (h_sp2) begin
				s_d.sp2 = WDATA & `LDO_MSK_SP2;
			end
			if (h_iro) begin
				s_d.iro = WDATA & `LDO_MSK_IRO;
			end
			if (h_irb) begin
				s_d.irb = WDATA;
			end
		end

		// parallel interrupt style
		ecp = s_q.ppm[1];
		lvl_cfg = ecp && (PP_ECR_MODE == `LDO_ECR_FIFO || PP_ECR_MODE == `LDO_ECR_ECP ||
			PP_ECR_MODE == `LDO_ECR_TEST);
		plain_cfg = s_q.ppm[2:0] == `LDO_PPM_PRN || s_q.ppm[2:0] == `LDO_PPM_SPP;
		pulse_cfg = !lvl_cfg && !plain_cfg && s_q.ppm[`LDO_B_PPTYPE];
		s_d.nack_q = PP_NACK;
		if (lvl_cfg) begin
			s_d.irq_o = PP_LVL_IRQ;
			s_d.irq_oe = 1'b1;
		end else if (!pulse_cfg) begin
			s_d.irq_o = PP_NACK;
			s_d.irq_oe = 1'b1;
		end else begin
			// one-cycle low drive per ack edge, pin floats otherwise
			s_d.irq_o = 1'b0;
			s_d.irq_oe = s_q.nack_q && !PP_NACK;
		end

		// timeout flag; a set in the clearing cycle wins
		s_d.srd_q = EPP_STAT_RD;
		tmo_clr = s_q.ppx[`LDO_B_TMOSEL] ? (s_q.srd_q && !EPP_STAT_RD) :
			(EPP_STAT_WR && EPP_STAT_WD);
		if (tmo_clr) begin
			s_d.tmo = 1'b0;
		end
		if (EPP_TMO_SET) begin
			s_d.tmo = 1'b1;
		end

		// uart interrupt sharing
		any_irq = U1_IRQ_IN || U2_IRQ_IN;
		s_d.u1o = s_q.sp1[`LDO_B_SHARE] ? any_irq : U1_IRQ_IN;
		s_d.u2o = s_q.sp1[`LDO_B_SHARE] ? any_irq : U2_IRQ_IN;

		// reserved infrared codes fall back to plain serial
		ir_on = s_q.iro[5:3] == `LDO_IR_IRDA || s_q.iro[5:3] == `LDO_IR_ASK;
		half = s_q.iro[`LDO_B_HALF];

		// blanking tail timer; prescaler idles outside the tail
		tick = s_q.pre == TICK_LAST;
		if (U2_TX_ACTIVE) begin
			s_d.bcnt = s_q.irb > BMAX ? BMAX : s_q.irb;
			s_d.pre = 14'h0000;
		end else if (s_q.bcnt != 8'h00) begin
			s_d.pre = tick ? 14'h0000 : s_q.pre + 14'h0001;
			if (tick) begin
				s_d.bcnt = s_q.bcnt - 8'h01;
			end
		end else begin
			s_d.pre = 14'h0000;
		end
		blank = ir_on && half && (U2_TX_ACTIVE || s_q.bcnt != 8'h00);

		// receive path, polarity and pin choice
		if (!ir_on) begin
			s_d.rxd = SECOND_SERIAL_RX;
		end else if (blank) begin
			s_d.rxd = 1'b1;
		end else begin
			s_d.rxd = (s_q.iro[`LDO_B_IRALT] ? ALT_INFRARED_RX : SECOND_SERIAL_RX) ^
				s_q.iro[`LDO_B_RXPOL];
		end

		// transmit path
		ir_tx = U2_TXD ^ s_q.iro[`LDO_B_TXPOL];
		s_d.alt_tx = ir_on && s_q.iro[`LDO_B_IRALT] ? ir_tx : 1'b0;
		if (ir_on && !s_q.iro[`LDO_B_IRALT]) begin
			s_d.tx_o = ir_tx;
			s_d.tx_oe = 1'b1;
		end else if (U2_TX_ACTIVE) begin
			s_d.tx_o = U2_TXD;
			s_d.tx_oe = 1'b1;
		end else begin
			s_d.tx_o = 1'b0;
			s_d.tx_oe = !idle_q;
		end

		// standby power-on restores defaults
		if (STBY_POR) begin
			s_d = ST_RST;
		end
	end

	// ==========================================
	// registers; soft reset is not wired in on purpose
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s_q <= ST_RST;
			quiet_q <= 1'b1;
		end else begin
			s_q <= s_d;
			quiet_q <= STBY_POR;
		end
	end

	// standby-domain bit: hard reset must not touch it
	always_ff @(posedge CORE_CLK) begin
		if (STBY_POR) begin
			idle_q <= 1'b0;
		end else if (WR && h_sp2) begin
			idle_q <= WDATA[`LDO_B_TXIDLE];
		end
	end

	// ==========================================
	// outputs
	assign RDATA = s_q.rdata;
	assign DRIVE0_OPTIONS = {s_q.drv0[`LDO_B_PRECOMP], s_q.drv0[4:3], s_q.drv0[1:0]};
	assign DRIVE1_OPTIONS = {s_q.drv1[`LDO_B_PRECOMP], s_q.drv1[4:3], s_q.drv1[1:0]};
	assign PP_MODE = s_q.ppm[2:0];
	assign PP_FIFO_THR = s_q.ppm[6:3];
	assign PP_IRQ_O = s_q.irq_o;
	assign PP_IRQ_OE = s_q.irq_oe;
	assign EPP_TIMEOUT_FLAG = s_q.tmo;
	assign U1_MIDI = s_q.sp1[`LDO_B_MIDI];
	assign U1_HS = s_q.sp1[`LDO_B_HS];
	assign U2_MIDI = s_q.sp2[`LDO_B_MIDI];
	assign U2_HS = s_q.sp2[`LDO_B_HS];
	assign U1_IRQ = s_q.u1o;
	assign U2_IRQ = s_q.u2o;
	assign IR_MODE = s_q.iro[5:3];
	assign U2_RXD = s_q.rxd;
	assign SECOND_SERIAL_TX_O = s_q.tx_o;
	assign SECOND_SERIAL_TX_OE = s_q.tx_oe;
	assign ALT_INFRARED_TX = s_q.alt_tx;

	// ==========================================
	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST || STBY_POR || quiet_q);  // reset shows one edge late

	sequence s_wr_drv1;
		WR && h_drv1;
	endsequence
	sequence s_rd_drv1;
		RD && h_drv1 && !WR;
	endsequence

	property p_unmapped_zero;
		RD && !(h_drv0 || h_drv1 || h_ppm || h_ppx || h_sp1 || h_sp2 || h_iro || h_irb)
			|=> RDATA == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_drv_rsv;
		RD && h_drv0 |=> RDATA[7] == 1'b0 && RDATA[5] == 1'b0 && RDATA[2] == 1'b0;
	endproperty
	a_drv_rsv: assert property (p_drv_rsv)
		else $error("drive reserved bits set");

	property p_drv1_echo;
		s_wr_drv1 ##1 s_rd_drv1 |=> RDATA == ($past(WDATA, 2) & `LDO_MSK_DRV);
	endproperty
	a_drv1_echo: assert property (p_drv1_echo)
		else $error("drive1 readback wrong");

	property p_precomp;
		WR && h_drv0 |=> DRIVE0_OPTIONS.precomp_off == $past(WDATA[6]);
	endproperty
	a_precomp: assert property (p_precomp)
		else $error("precomp bit not applied");

	property p_ppmode;
		WR && h_ppm |=> PP_MODE == $past(WDATA[2:0]) && PP_FIFO_THR == $past(WDATA[6:3]);
	endproperty
	a_ppmode: assert property (p_ppmode)
		else $error("parallel mode fields wrong");

	property p_pulse;
		pulse_cfg && $fell(PP_NACK) |=> PP_IRQ_OE && !PP_IRQ_O;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("no low pulse on ack");

	property p_release;
		pulse_cfg && !$fell(PP_NACK) |=> !PP_IRQ_OE;
	endproperty
	a_release: assert property (p_release)
		else $error("interrupt pin not released");

	property p_follow;
		!pulse_cfg && !lvl_cfg |=> PP_IRQ_OE && PP_IRQ_O == $past(PP_NACK);
	endproperty
	a_follow: assert property (p_follow)
		else $error("interrupt does not follow ack");

	property p_level;
		lvl_cfg |=> PP_IRQ_OE && PP_IRQ_O == $past(PP_LVL_IRQ);
	endproperty
	a_level: assert property (p_level)
		else $error("level interrupt wrong");

	property p_tmo_set;
		EPP_TMO_SET |=> EPP_TIMEOUT_FLAG;
	endproperty
	a_tmo_set: assert property (p_tmo_set)
		else $error("timeout set lost");

	property p_share;
		s_q.sp1[`LDO_B_SHARE] && (U1_IRQ_IN || U2_IRQ_IN) |=> U1_IRQ && U2_IRQ;
	endproperty
	a_share: assert property (p_share)
		else $error("shared interrupt not on both");

	property p_idle_z;
		idle_q && !ir_on && !U2_TX_ACTIVE |=> !SECOND_SERIAL_TX_OE;
	endproperty
	a_idle_z: assert property (p_idle_z)
		else $error("transmit pin driven when idle");

	property p_blank;
		ir_on && half && U2_TX_ACTIVE |=> U2_RXD;
	endproperty
	a_blank: assert property (p_blank)
		else $error("receiver not blanked");
endmodule
`default_nettype wire

// ===== hdl/ldo_defs.svh
// constants of the logical device option register bank
// assumes a 100 MHz core clock and a 16-bit config address
`ifndef LDO_DEFS_SVH
`define LDO_DEFS_SVH
// ==========================================
// logical device numbers and indexes
`define LDO_LD_FDC 8'h00
`define LDO_LD_PP 8'h03
`define LDO_LD_SP1 8'h04
`define LDO_LD_SP2 8'h05
`define LDO_IX_DRV0 8'hf4
`define LDO_IX_DRV1 8'hf5
`define LDO_IX_PPM 8'hf0
`define LDO_IX_PPX 8'hf1
`define LDO_IX_SER 8'hf0
`define LDO_IX_IRO 8'hf1
`define LDO_IX_IRB 8'hf2
// ==========================================
// writable bit masks
`define LDO_MSK_DRV 8'h5b
`define LDO_MSK_PPX 8'h10
`define LDO_MSK_SP1 8'h83
`define LDO_MSK_SP2 8'h03
`define LDO_MSK_IRO 8'h7f
// ==========================================
// reset values
`define LDO_RST_DRV 8'h00
`define LDO_RST_PPM 8'h3c
`define LDO_RST_PPX 8'h00
`define LDO_RST_SER 8'h00
`define LDO_RST_IRO 8'h02
`define LDO_RST_IRB 8'h03
// ==========================================
// field positions
`define LDO_B_PRECOMP 6
`define LDO_B_PPTYPE 7
`define LDO_B_TMOSEL 4
`define LDO_B_MIDI 0
`define LDO_B_HS 1
`define LDO_B_SHARE 7
`define LDO_B_TXIDLE 5
`define LDO_B_RXPOL 0
`define LDO_B_TXPOL 1
`define LDO_B_HALF 2
`define LDO_B_IRALT 6
// ==========================================
// mode codes
`define LDO_PPM_PRN 3'h4
`define LDO_PPM_SPP 3'h0
`define LDO_ECR_FIFO 3'h2
`define LDO_ECR_ECP 3'h3
`define LDO_ECR_TEST 3'h6
`define LDO_IR_IRDA 3'h1
`define LDO_IR_ASK 3'h2
// ==========================================
// timing
`define LDO_CLK_MHZ 100
`define LDO_TICK_US 100
`define LDO_BLANK_MAX_MS 10
`define LDO_BLANK_MAX (`LDO_BLANK_MAX_MS * 1000 / `LDO_TICK_US)
`endif

// ===== hdl/ldo_pkg.sv
// types of the logical device option register bank
// assumes ldo_defs.svh for all numeric constants
`default_nettype none
package ldo_pkg;
	typedef struct packed {
		logic       precomp_off;
		logic [1:0] rate_table_bits;
		logic [1:0] drive_type_bits;
	} ldo_drive_t;

	typedef struct packed {
		logic [7:0]  drv0;
		logic [7:0]  drv1;
		logic [7:0]  ppm;
		logic [7:0]  ppx;
		logic [7:0]  sp1;
		logic [7:0]  sp2;
		logic [7:0]  iro;
		logic [7:0]  irb;
		logic [7:0]  rdata;
		logic        tmo;
		logic        nack_q;
		logic        srd_q;
		logic        irq_o;
		logic        irq_oe;
		logic        u1o;
		logic        u2o;
		logic        tx_o;
		logic        tx_oe;
		logic        alt_tx;
		logic        rxd;
		logic [13:0] pre;
		logic [7:0]  bcnt;
	} ldo_st_t;
endpackage
`default_nettype wire

// ===== verification/tb_logical_device_option_regs.sv
// testbench of the option register bank: config port tasks, port checks
// assumes hdl/ldo_defs.svh and hdl/ldo_pkg.sv are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_logical_device_option_regs;
	import ldo_pkg::*;
	logic CORE_CLK, RST, STBY_POR, WR, RD, PP_NACK, PP_LVL_IRQ;
	logic EPP_TMO_SET, EPP_STAT_WR, EPP_STAT_WD, EPP_STAT_RD;
	logic U1_IRQ_IN, U2_IRQ_IN, U2_TXD, U2_TX_ACTIVE, SECOND_SERIAL_RX;
	logic ALT_INFRARED_RX, PP_IRQ_O, PP_IRQ_OE, EPP_TIMEOUT_FLAG;
	logic U1_MIDI, U1_HS, U2_MIDI, U2_HS, U1_IRQ, U2_IRQ, U2_RXD;
	logic SECOND_SERIAL_TX_O, SECOND_SERIAL_TX_OE, ALT_INFRARED_TX;
	logic [15:0] ADDR;
	logic [7:0]  WDATA, RDATA;
	logic [2:0]  PP_ECR_MODE, PP_MODE, IR_MODE;
	logic [3:0]  PP_FIFO_THR;
	ldo_drive_t  DRIVE0_OPTIONS, DRIVE1_OPTIONS;
	int          error_cnt, checked, cyc, n;
	logic [15:0] adr [8] = '{16'h00f4, 16'h00f5, 16'h03f0, 16'h03f1,
		16'h04f0, 16'h05f0, 16'h05f1, 16'h05f2};
	logic [7:0]  rst_v [8] = '{8'h00, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
	logic [7:0]  msk_v [8] = '{8'h5b, 8'h5b, 8'hff, 8'h10, 8'h83, 8'h23, 8'h7f, 8'hff};

	// short tick so blanking fits in a few cycles
	ldo_regs #(.TICK_CYCLES(4)) u_dut (.CORE_CLK, .RST, .STBY_POR, .ADDR, .WDATA,
		.WR, .RD, .RDATA, .DRIVE0_OPTIONS, .DRIVE1_OPTIONS, .PP_MODE, .PP_FIFO_THR,
		.PP_ECR_MODE, .PP_NACK, .PP_LVL_IRQ, .PP_IRQ_O, .PP_IRQ_OE, .EPP_TMO_SET,
		.EPP_STAT_WR, .EPP_STAT_WD, .EPP_STAT_RD, .EPP_TIMEOUT_FLAG, .U1_MIDI,
		.U1_HS, .U2_MIDI, .U2_HS, .U1_IRQ_IN, .U2_IRQ_IN, .U1_IRQ, .U2_IRQ,
		.IR_MODE, .U2_TXD, .U2_TX_ACTIVE, .U2_RXD, .SECOND_SERIAL_TX_O,
		.SECOND_SERIAL_TX_OE, .SECOND_SERIAL_RX, .ALT_INFRARED_RX, .ALT_INFRARED_TX);

	// ==========================================
	// helpers
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask
	// lands 1 ns past the edge so registered outputs have settled
	task automatic stp(input int k);
		repeat (k) @(posedge CORE_CLK);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, exp);
	endtask
	// drives ack low / level high, then the reverse; expects follow or level
	task automatic ppi(input logic [7:0] m, input logic [2:0] e, input logic lvl);
		wr(16'h03f0, m);
		@(posedge CORE_CLK);
		PP_ECR_MODE <= e;
		PP_NACK <= 1'b0;
		PP_LVL_IRQ <= 1'b1;
		stp(3);
		chk({6'h0, PP_IRQ_OE, PP_IRQ_O}, {6'h0, 1'b1, lvl});
		@(posedge CORE_CLK);
		PP_NACK <= 1'b1;
		PP_LVL_IRQ <= 1'b0;
		stp(3);
		chk({6'h0, PP_IRQ_OE, PP_IRQ_O}, {6'h0, 1'b1, !lvl});
	endtask
	task automatic tset();
		@(posedge CORE_CLK);
		EPP_TMO_SET <= 1'b1;
		@(posedge CORE_CLK);
		EPP_TMO_SET <= 1'b0;
		stp(2);
	endtask
	task automatic swr(input logic d);
		@(posedge CORE_CLK);
		EPP_STAT_WR <= 1'b1;
		EPP_STAT_WD <= d;
		@(posedge CORE_CLK);
		EPP_STAT_WR <= 1'b0;
		stp(2);
	endtask
	task automatic txa(input logic a);
		@(posedge CORE_CLK);
		U2_TX_ACTIVE <= a;
		stp(3);
	endtask

	// ==========================================
	// clock and hang guard
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{RST, STBY_POR, WR, RD, PP_NACK, PP_LVL_IRQ, EPP_TMO_SET} = 7'h64;
		{EPP_STAT_WR, EPP_STAT_WD, EPP_STAT_RD, U1_IRQ_IN, U2_IRQ_IN} = 5'h00;
		{U2_TXD, U2_TX_ACTIVE, SECOND_SERIAL_RX, ALT_INFRARED_RX} = 4'h0;
		{ADDR, WDATA, PP_ECR_MODE, error_cnt, checked, cyc} = '0;
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		STBY_POR <= 1'b0;
		stp(1);
		// defaults, masks, reserved bits and unmapped places
		for (int i = 0; i < 8; i++) rd(adr[i], rst_v[i]);
		for (int i = 0; i < 8; i++) begin
			wr(adr[i], 8'hff);
			rd(adr[i], msk_v[i]);
			wr(adr[i], 8'h00);
			rd(adr[i], 8'h00);
		end
		wr(16'h00f3, 8'hff);
		rd(16'h00f3, 8'h00);
		wr(16'h06f0, 8'hff);
		rd(16'h06f0, 8'h00);
		// drive fields
		wr(16'h00f4, 8'hff);
		wr(16'h00f5, 8'h40);
		stp(2);
		chk(8'(DRIVE0_OPTIONS), 8'h1f);
		chk(8'(DRIVE1_OPTIONS), 8'h10);
		// write then read with no gap between the strobes
		@(posedge CORE_CLK);
		ADDR <= 16'h00f5;
		WDATA <= 8'hde;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, 8'h5a);
		// every parallel mode code, threshold held at 0111
		for (int m = 0; m < 8; m++) begin
			wr(16'h03f0, {5'h07, m[2:0]});
			stp(2);
			chk(8'(PP_MODE), 8'(m));
			chk(8'(PP_FIFO_THR), 8'h07);
		end
		// interrupt styles
		ppi(8'h39, 3'h0, 1'b0);
		ppi(8'h3d, 3'h0, 1'b0);
		ppi(8'hbc, 3'h0, 1'b0);
		ppi(8'hb8, 3'h0, 1'b0);
		ppi(8'h3a, 3'h1, 1'b0);
		ppi(8'h3f, 3'h4, 1'b0);
		ppi(8'h3a, 3'h3, 1'b1);
		ppi(8'h3b, 3'h2, 1'b1);
		ppi(8'hbf, 3'h6, 1'b1);
		wr(16'h03f0, 8'hb9);
		@(posedge CORE_CLK);
		PP_ECR_MODE <= 3'h0;
		stp(3);
		chk({7'h0, PP_IRQ_OE}, 8'h00);
		@(posedge CORE_CLK);
		PP_NACK <= 1'b0;
		n = 0;
		repeat (6) begin
			stp(1);
			if (PP_IRQ_OE === 1'b1) begin
				n++;
				chk({7'h0, PP_IRQ_O}, 8'h00);
			end
		end
		chk(8'(n), 8'h01);
		// timeout flag, both clearing policies
		wr(16'h03f1, 8'h00);
		tset();
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h01);
		swr(1'b0);
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h01);
		swr(1'b1);
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h00);
		wr(16'h03f1, 8'h10);
		tset();
		swr(1'b1);
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h01);
		@(posedge CORE_CLK);
		EPP_STAT_RD <= 1'b1;
		stp(3);
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h01);
		@(posedge CORE_CLK);
		EPP_STAT_RD <= 1'b0;
		stp(3);
		chk({7'h0, EPP_TIMEOUT_FLAG}, 8'h00);
		// uart options and interrupt sharing
		wr(16'h04f0, 8'h01);
		wr(16'h05f0, 8'h02);
		@(posedge CORE_CLK);
		U1_IRQ_IN <= 1'b1;
		stp(2);
		chk({4'h0, U1_MIDI, U1_HS, U2_MIDI, U2_HS}, 8'h09);
		chk({6'h0, U1_IRQ, U2_IRQ}, 8'h02);
		wr(16'h04f0, 8'h80);
		stp(2);
		chk({6'h0, U1_IRQ, U2_IRQ}, 8'h03);
		@(posedge CORE_CLK);
		U1_IRQ_IN <= 1'b0;
		U2_IRQ_IN <= 1'b1;
		stp(2);
		chk({6'h0, U1_IRQ, U2_IRQ}, 8'h03);
		// transmit pin idle style, then a mid-run hard reset
		wr(16'h05f1, 8'h00);
		stp(2);
		chk({6'h0, SECOND_SERIAL_TX_OE, SECOND_SERIAL_TX_O}, 8'h02);
		wr(16'h05f0, 8'h23);
		stp(2);
		chk({7'h0, SECOND_SERIAL_TX_OE}, 8'h00);
		@(posedge CORE_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(16'h05f0, 8'h20);
		@(posedge CORE_CLK);
		STBY_POR <= 1'b1;
		@(posedge CORE_CLK);
		STBY_POR <= 1'b0;
		rd(16'h05f0, 8'h00);
		// infrared polarity, protocol and pin routing
		@(posedge CORE_CLK);
		U2_TXD <= 1'b1;
		SECOND_SERIAL_RX <= 1'b1;
		wr(16'h05f1, 8'h0b);
		stp(2);
		chk({2'h0, IR_MODE, SECOND_SERIAL_TX_OE, SECOND_SERIAL_TX_O, U2_RXD}, 8'h0c);
		wr(16'h05f1, 8'h10);
		stp(2);
		chk({2'h0, IR_MODE, SECOND_SERIAL_TX_OE, SECOND_SERIAL_TX_O, U2_RXD}, 8'h17);
		wr(16'h05f1, 8'h19);
		stp(2);
		chk({7'h0, U2_RXD}, 8'h01);
		wr(16'h05f1, 8'h4a);
		@(posedge CORE_CLK);
		U2_TXD <= 1'b0;
		stp(2);
		chk({6'h0, ALT_INFRARED_TX, U2_RXD}, 8'h02);
		// half duplex blanking: programmed ticks, zero count, full duplex
		@(posedge CORE_CLK);
		SECOND_SERIAL_RX <= 1'b0;
		wr(16'h05f2, 8'h02);
		wr(16'h05f1, 8'h0c);
		txa(1'b1);
		chk({7'h0, U2_RXD}, 8'h01);
		txa(1'b0);
		chk({7'h0, U2_RXD}, 8'h01);
		stp(5);
		chk({7'h0, U2_RXD}, 8'h01);
		stp(1);
		chk({7'h0, U2_RXD}, 8'h00);
		wr(16'h05f2, 8'h00);
		txa(1'b1);
		txa(1'b0);
		chk({7'h0, U2_RXD}, 8'h00);
		wr(16'h05f1, 8'h08);
		txa(1'b1);
		chk({7'h0, U2_RXD}, 8'h00);
		@(posedge CORE_CLK);
		U2_TXD <= 1'b1;
		wr(16'h05f1, 8'h00);
		stp(2);
		chk({6'h0, SECOND_SERIAL_TX_OE, SECOND_SERIAL_TX_O}, 8'h03);
		complete_run();
	end
endmodule
`default_nettype wire
